// ---- rtl/ssw_exec.sv ----
// Decode and execute of the subtract and word-store group
//
`timescale 1ns/1ps
`default_nettype none
module ssw_exec #(
	parameter bit RELEASE_SIX = 1'b1,
	parameter bit MISALIGN_OK = 1'b1,
	parameter int PADDR_W = 48
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	// Issue
	input wire logic issue_valid_in,
	input wire ssw_pkg::ssw_issue_t issue_in,
	// Core state
	input wire logic kernel_mode_in,
	input wire logic fpu_usable_in,
	input wire logic cop2_usable_in,
	input wire logic enhanced_vaddr_present_in,
	input wire logic big_endian_flag_in,
	input wire logic reversed_endian_flag_in,
	input wire logic [1:0] fp_control_status_rm_in,
	// Translation
	output ssw_pkg::ssw_xlate_req_t xlate_req_out,
	input wire ssw_pkg::ssw_xlate_rsp_t xlate_rsp_in,
	// Floating-point arithmetic
	output ssw_pkg::ssw_fp_req_t fp_req_out,
	input wire logic [63:0] fp_result_in,
	input wire ssw_pkg::ssw_fp_flags_t fp_flags_in,
	// Memory store
	output logic store_valid_out,
	output ssw_pkg::ssw_store_t store_out,
	// Writeback and exception
	output ssw_pkg::ssw_wb_t wb_out,
	output logic exc_valid_out,
	output ssw_pkg::ssw_exc_t exc_code_out,
	output ssw_pkg::ssw_fp_flags_t exc_fp_flags_out,
	output ssw_pkg::ssw_op_t op_out
);
	import ssw_pkg::*;

	// The physical address slices below are fixed at a 48-bit answer
	if (PADDR_W != 48) begin : g_paddr_check
		$error("ssw_exec: PADDR_W must be 48");
	end

	function automatic logic [63:0] sext32(input logic [31:0] v);
		sext32 = {{32{v[31]}}, v};
	endfunction

	function automatic logic [63:0] lane_word(input logic [31:0] v, input logic [2:0] sel);
		lane_word = {32'h0, v} << {sel, 3'h0};
	endfunction

	// Big-endian lanes and reversed-endian addresses flip the same bit
	function automatic logic [2:0] endian_flip(input logic flag);
		endian_flip = flag ? BE_SEL_FLIP : 3'h0;
	endfunction

	// Every word store shares the address, lane and exception paths
	function automatic logic is_store_op(input ssw_op_t o);
		is_store_op = (o == SSW_OP_SW) || (o == SSW_OP_SWU)
			|| (o == SSW_OP_SWF) || (o == SSW_OP_COP2_STORE_WORD);
	endfunction

	logic [31:0] w;
	ssw_op_t op;
	logic [63:0] disp;
	logic [63:0] vaddr;
	logic [31:0] src_word;
	logic [32:0] diff33;
	logic ovf;
	logic [2:0] bytesel;
	logic enh_seg;
	ssw_exc_t exc;
	logic is_store;

	assign w = issue_in.word;

	// Decode; operands gpr_a is register field 25..21, gpr_b field 20..16
	always_comb begin
		op = SSW_OP_NONE;
		if (issue_valid_in) begin
			if (w[31:26] == OP_MAJOR_FP && w[7:0] == FN_FP_SUB && !w[10]) begin
				op = SSW_OP_FSUB;
			end else if (w[31:26] == OP_MAJOR_A && w[9:0] == FN_TRAP_SUB) begin
				op = SSW_OP_TSUB;
			end else if (w[31:26] == OP_MAJOR_A && w[9:0] == FN_WRAP_SUB) begin
				op = SSW_OP_WSUB;
			end else if (w[31:26] == OP_STORE_WORD) begin
				op = SSW_OP_SW;
			end else if (w[31:26] == OP_MAJOR_C && w[15:12] == SUB_ENH_STORE
				&& w[11:9] == SUB_USER_STORE) begin
				op = SSW_OP_SWU;
			end else if (w[31:26] == OP_FP_STORE) begin
				op = SSW_OP_SWF;
			end else if (w[31:26] == OP_MAJOR_B && w[15:12] == SUB_COP2_STORE && !w[11]) begin
				op = SSW_OP_COP2_STORE_WORD;
			end
		end
	end

	assign is_store = is_store_op(op);

	// Displacement width by instruction
	always_comb begin
		unique case (op)
			SSW_OP_SWU: disp = {{55{w[8]}}, w[8:0]};
			SSW_OP_COP2_STORE_WORD: disp = {{53{w[10]}}, w[10:0]};
			default: disp = {{48{w[15]}}, w[15:0]};
		endcase
	end

	// Base register is the 20..16 field
	assign vaddr = 64'(issue_in.gpr_b + disp);

	always_comb begin
		unique case (op)
			SSW_OP_SWF: src_word = issue_in.fpr_val[31:0];
			SSW_OP_COP2_STORE_WORD: src_word = issue_in.cop2_val[31:0];
			default: src_word = issue_in.gpr_a[31:0];
		endcase
	end

	// Minuend is the 20..16 field, subtrahend 25..21; high bits assumed sign copies
	assign diff33 = {issue_in.gpr_b[31], issue_in.gpr_b[31:0]}
		- {issue_in.gpr_a[31], issue_in.gpr_a[31:0]};
	assign ovf = diff33[32] != diff33[31];

	assign bytesel = vaddr[2:0] ^ endian_flip(big_endian_flag_in);
	assign enh_seg = (xlate_rsp_in.seg_mode == SEG_MAPPED_USER_KERNEL_MODE) || (xlate_rsp_in.seg_mode == SEG_MAPPED_USER_SUPER_MODE)
		|| (xlate_rsp_in.seg_mode == SEG_UNMAPPED_USER_MODE);

	// Translation request; user mapping only for the user-space store
	assign xlate_req_out.vaddr = vaddr;
	assign xlate_req_out.user_map = (op == SSW_OP_SWU)
		&& (xlate_rsp_in.seg_mode == SEG_MAPPED_USER_KERNEL_MODE);

	assign fp_req_out.fmt = w[9:8];
	assign fp_req_out.minuend = issue_in.gpr_b;
	assign fp_req_out.subtrahend = issue_in.gpr_a;
	assign fp_req_out.round_mode = fp_control_status_rm_in;

	// Exception priority: decode faults, then address, then translation
	always_comb begin
		exc = SSW_EXC_NONE;
		unique case (op)
			SSW_OP_FSUB: begin
				if (!fpu_usable_in) begin
					exc = SSW_EXC_COP_UNUSABLE;
				end else if (RELEASE_SIX && w[9:8] == FMT_PAIRED) begin
					exc = SSW_EXC_RESERVED;
				end else if (w[9:8] != FMT_SINGLE && w[9:8] != FMT_DOUBLE
					&& w[9:8] != FMT_PAIRED) begin
					exc = SSW_EXC_RESERVED;
				end else if (|fp_flags_in) begin
					exc = SSW_EXC_FPU;
				end
			end
			SSW_OP_TSUB: begin
				if (ovf) begin
					exc = SSW_EXC_OVERFLOW;
				end
			end
			SSW_OP_WSUB: exc = SSW_EXC_NONE;
			SSW_OP_SW, SSW_OP_SWU, SSW_OP_SWF, SSW_OP_COP2_STORE_WORD: begin
				if (op == SSW_OP_SWU && (!enhanced_vaddr_present_in)) begin
					exc = SSW_EXC_RESERVED;
				end else if (op == SSW_OP_SWU && (!kernel_mode_in || !enh_seg)) begin
					exc = SSW_EXC_ADDR_ERR;
				end else if (op == SSW_OP_SWF && !fpu_usable_in) begin
					exc = SSW_EXC_COP_UNUSABLE;
				end else if (op == SSW_OP_COP2_STORE_WORD && !cop2_usable_in) begin
					exc = SSW_EXC_COP_UNUSABLE;
				end else if (|vaddr[1:0] && !(RELEASE_SIX && MISALIGN_OK)) begin
					exc = SSW_EXC_ADDR_ERR;
				end else if (xlate_rsp_in.refill) begin
					exc = SSW_EXC_TLB_REFILL;
				end else if (xlate_rsp_in.invalid) begin
					exc = SSW_EXC_TLB_INVALID;
				end else if (xlate_rsp_in.modified && op != SSW_OP_SWU) begin
					exc = SSW_EXC_TLB_MODIFIED;
				end else if (xlate_rsp_in.bus_err && op == SSW_OP_SWU) begin
					exc = SSW_EXC_BUS_ERR;
				end else if (xlate_rsp_in.watch) begin
					exc = SSW_EXC_WATCH;
				end
			end
			default: exc = SSW_EXC_NONE;
		endcase
	end

	// Flopped output fields; each concern has its own process
	logic [47:0] st_paddr;
	logic [63:0] st_vaddr;
	logic [63:0] st_data;
	logic [7:0] st_byte_en;
	logic [2:0] st_cca;
	logic wb_gpr_we;
	logic wb_fpr_we;
	logic [4:0] wb_dest;
	logic [1:0] wb_fmt;
	logic [63:0] wb_value;

	// Store and writeback outputs are assembled from the flops; the translation and fp requests stay combinational
	assign store_out = {st_paddr, st_vaddr, st_data, st_byte_en, st_cca};
	assign wb_out = {wb_gpr_we, wb_fpr_we, wb_dest, wb_fmt, wb_value};

	// A faulting store is dropped here, so memory never sees part of it
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			store_valid_out <= 1'b0;
		end else begin
			store_valid_out <= is_store && (exc == SSW_EXC_NONE);
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_vaddr <= '0;
		end else begin
			st_vaddr <= vaddr;
		end
	end

	// Reversed endianness moves the word to the other half of the doubleword
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_paddr <= '0;
		end else begin
			st_paddr <= {xlate_rsp_in.paddr[47:3],
				xlate_rsp_in.paddr[2:0] ^ endian_flip(reversed_endian_flag_in)};
		end
	end

	// Selectors above four push the upper bytes off the lane; a known limit
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_data <= '0;
		end else begin
			st_data <= lane_word(src_word, bytesel);
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_byte_en <= '0;
		end else begin
			st_byte_en <= 8'(8'h0F << bytesel);
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_cca <= '0;
		end else begin
			st_cca <= xlate_rsp_in.cca;
		end
	end

	// Writeback stage
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wb_dest <= '0;
		end else begin
			wb_dest <= w[15:11];
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wb_fmt <= '0;
		end else begin
			wb_fmt <= w[9:8];
		end
	end

	// An overflowing trap subtract must leave the destination untouched
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wb_gpr_we <= 1'b0;
		end else begin
			wb_gpr_we <= (op == SSW_OP_WSUB)
				|| (op == SSW_OP_TSUB && !ovf);
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wb_fpr_we <= 1'b0;
		end else begin
			wb_fpr_we <= (op == SSW_OP_FSUB) && (exc == SSW_EXC_NONE);
		end
	end

	// Integer results keep only the low word, its sign filling the top half; FSUB keeps all 64 unit bits
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wb_value <= '0;
		end else begin
			wb_value <= (op == SSW_OP_FSUB) ? fp_result_in
				: sext32(diff33[31:0]);
		end
	end

	// Exception report stage
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			exc_valid_out <= 1'b0;
		end else begin
			exc_valid_out <= exc != SSW_EXC_NONE;
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			exc_code_out <= SSW_EXC_NONE;
		end else begin
			exc_code_out <= exc;
		end
	end

	// Flags of other instructions are masked so stale unit flags never leak
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			exc_fp_flags_out <= '0;
		end else begin
			exc_fp_flags_out <= (op == SSW_OP_FSUB) ? fp_flags_in : '0;
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			op_out <= SSW_OP_NONE;
		end else begin
			op_out <= op;
		end
	end
endmodule
`default_nettype wire

// ---- rtl/ssw_pkg.sv ----
// Package for the subtract and word-store decode and execute block
package ssw_pkg;
	localparam logic [5:0] OP_MAJOR_FP = 6'h15;
	localparam logic [7:0] FN_FP_SUB = 8'h70;
	localparam logic [5:0] OP_MAJOR_A = 6'h00;
	localparam logic [9:0] FN_TRAP_SUB = 10'h190;
	localparam logic [9:0] FN_WRAP_SUB = 10'h1D0;
	localparam logic [5:0] OP_STORE_WORD = 6'h3E;
	localparam logic [5:0] OP_MAJOR_C = 6'h18;
	localparam logic [3:0] SUB_ENH_STORE = 4'hA;
	localparam logic [2:0] SUB_USER_STORE = 3'h7;
	localparam logic [5:0] OP_FP_STORE = 6'h26;
	localparam logic [5:0] OP_MAJOR_B = 6'h08;
	localparam logic [3:0] SUB_COP2_STORE = 4'h8;
	localparam logic [1:0] FMT_SINGLE = 2'h0;
	localparam logic [1:0] FMT_DOUBLE = 2'h1;
	localparam logic [1:0] FMT_PAIRED = 2'h2;
	localparam logic [2:0] BE_SEL_FLIP = 3'h4;
	localparam logic [1:0] SEG_MAPPED_USER_KERNEL_MODE = 2'h1;
	localparam logic [1:0] SEG_MAPPED_USER_SUPER_MODE = 2'h2;
	localparam logic [1:0] SEG_UNMAPPED_USER_MODE = 2'h3;

	typedef enum logic [3:0] {
		SSW_OP_NONE = 4'h0,
		SSW_OP_FSUB = 4'h1,
		SSW_OP_TSUB = 4'h2,
		SSW_OP_WSUB = 4'h3,
		SSW_OP_SW = 4'h4,
		SSW_OP_SWU = 4'h5,
		SSW_OP_SWF = 4'h6,
		SSW_OP_COP2_STORE_WORD = 4'h7
	} ssw_op_t;

	typedef enum logic [3:0] {
		SSW_EXC_NONE = 4'h0,
		SSW_EXC_OVERFLOW = 4'h1,
		SSW_EXC_ADDR_ERR = 4'h2,
		SSW_EXC_RESERVED = 4'h3,
		SSW_EXC_COP_UNUSABLE = 4'h4,
		SSW_EXC_TLB_REFILL = 4'h5,
		SSW_EXC_TLB_INVALID = 4'h6,
		SSW_EXC_TLB_MODIFIED = 4'h7,
		SSW_EXC_BUS_ERR = 4'h8,
		SSW_EXC_WATCH = 4'h9,
		SSW_EXC_FPU = 4'hA
	} ssw_exc_t;

	// Instruction presented by issue together with operands
	typedef struct packed {
		logic [31:0] word;
		logic [63:0] gpr_a;
		logic [63:0] gpr_b;
		logic [63:0] fpr_val;
		logic [63:0] cop2_val;
	} ssw_issue_t;

	// Request to translation
	typedef struct packed {
		logic [63:0] vaddr;
		logic user_map;
	} ssw_xlate_req_t;

	// Answer from translation, same cycle
	typedef struct packed {
		logic [47:0] paddr;
		logic [2:0] cca;
		logic [1:0] seg_mode;
		logic refill;
		logic invalid;
		logic modified;
		logic bus_err;
		logic watch;
	} ssw_xlate_rsp_t;

	// Store presented to memory
	typedef struct packed {
		logic [47:0] paddr;
		logic [63:0] vaddr;
		logic [63:0] data;
		logic [7:0] byte_en;
		logic [2:0] cca;
	} ssw_store_t;

	// Result for the register file
	typedef struct packed {
		logic gpr_we;
		logic fpr_we;
		logic [4:0] dest;
		logic [1:0] fmt;
		logic [63:0] value;
	} ssw_wb_t;

	// Request to the floating-point arithmetic unit
	typedef struct packed {
		logic [1:0] fmt;
		logic [63:0] minuend;
		logic [63:0] subtrahend;
		logic [1:0] round_mode;
	} ssw_fp_req_t;

	// Flags returned by the arithmetic unit
	typedef struct packed {
		logic inexact;
		logic overflow;
		logic underflow;
		logic invalid;
		logic unimpl;
	} ssw_fp_flags_t;
endpackage

// ---- verif/ssw_far_model.sv ----
// Behavioural translation and floating-point unit beside the block
`timescale 1ns/1ps
`default_nettype none
module ssw_far_model
	import ssw_pkg::*;
(
	// From the block
	input wire ssw_pkg::ssw_xlate_req_t req_in,
	input wire ssw_pkg::ssw_fp_req_t fp_req_in,
	// Bench controls
	input wire logic [1:0] seg_in,
	input wire logic [4:0] fault_in,
	input wire logic fp_bad_in,
	// Answers
	output ssw_pkg::ssw_xlate_rsp_t rsp_out,
	output logic [63:0] fp_res_out,
	output ssw_pkg::ssw_fp_flags_t fp_flags_out
);
	// Identity map keeps expected physical addresses trivial to derive
	assign rsp_out = {req_in.vaddr[47:0], 3'h3, seg_in, fault_in};
	// Integer difference stands in for rounding; only forwarding is judged
	assign fp_res_out = fp_req_in.minuend - fp_req_in.subtrahend;
	assign fp_flags_out = {fp_bad_in, 4'h0};
endmodule
`default_nettype wire

// ---- verif/ssw_checker.sv ----
// Concurrent checks on the subtract and word-store block ports
`timescale 1ns/1ps
`default_nettype none
module ssw_checker
	import ssw_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	// Inputs watched
	input wire logic issue_valid_in,
	input wire ssw_pkg::ssw_issue_t issue_in,
	input wire logic kernel_mode_in,
	input wire logic enhanced_vaddr_present_in,
	input wire logic big_endian_flag_in,
	input wire logic [1:0] fp_control_status_rm_in,
	input wire ssw_pkg::ssw_xlate_rsp_t xlate_rsp_in,
	// Outputs watched
	input wire ssw_pkg::ssw_xlate_req_t xlate_req_out,
	input wire ssw_pkg::ssw_fp_req_t fp_req_out,
	input wire logic store_valid_out,
	input wire ssw_pkg::ssw_store_t store_out,
	input wire ssw_pkg::ssw_wb_t wb_out,
	input wire logic exc_valid_out,
	input wire ssw_pkg::ssw_exc_t exc_code_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);
	logic [31:0] wdiff;
	logic [5:0] major;
	logic ovf;
	assign wdiff = issue_in.gpr_b[31:0] - issue_in.gpr_a[31:0];
	assign major = issue_in.word[31:26];
	assign ovf = issue_in.gpr_b[31] != issue_in.gpr_a[31] && wdiff[31] != issue_in.gpr_b[31];
	sequence s_sub(logic [9:0] fn);
		issue_valid_in && major == OP_MAJOR_A && issue_in.word[9:0] == fn;
	endsequence
	sequence s_fsub;
		issue_valid_in && major == OP_MAJOR_FP && issue_in.word[7:0] == FN_FP_SUB;
	endsequence
	sequence s_swu;
		issue_valid_in && major == OP_MAJOR_C && issue_in.word[15:9] == {SUB_ENH_STORE, SUB_USER_STORE};
	endsequence
	property p_quiet; !issue_valid_in |=> !store_valid_out && !exc_valid_out; endproperty
	a_quiet: assert property (p_quiet) else $error("output without issue");
	property p_excl; store_valid_out |-> !exc_valid_out; endproperty
	a_excl: assert property (p_excl) else $error("store beside exception");
	property p_wrap; s_sub(FN_WRAP_SUB) |=> !exc_valid_out && wb_out.gpr_we
		&& wb_out.value == {{32{$past(wdiff[31])}}, $past(wdiff)}; endproperty
	a_wrap: assert property (p_wrap) else $error("wrapping result wrong");
	property p_trap; s_sub(FN_TRAP_SUB) ##0 ovf |=> exc_valid_out
		&& exc_code_out == SSW_EXC_OVERFLOW && !wb_out.gpr_we; endproperty
	a_trap: assert property (p_trap) else $error("overflow not trapped");
	property p_fwd; s_fsub |-> fp_req_out.minuend == issue_in.gpr_b
		&& fp_req_out.round_mode == fp_control_status_rm_in; endproperty
	a_fwd: assert property (p_fwd) else $error("fp request wrong");
	property p_paired; s_fsub ##0 issue_in.word[9:8] == FMT_PAIRED |=> !wb_out.fpr_we; endproperty
	a_paired: assert property (p_paired) else $error("paired format written");
	property p_lane; store_valid_out |-> store_out.byte_en == 8'(8'h0F <<
		{store_out.vaddr[2] ^ $past(big_endian_flag_in), store_out.vaddr[1:0]}); endproperty
	a_lane: assert property (p_lane) else $error("byte lane wrong");
	property p_absent; s_swu ##0 !enhanced_vaddr_present_in |=> exc_valid_out
		&& exc_code_out == SSW_EXC_RESERVED; endproperty
	a_absent: assert property (p_absent) else $error("absent store ran");
	property p_kern; s_swu ##0 enhanced_vaddr_present_in && !kernel_mode_in |=> !store_valid_out;
	endproperty
	a_kern: assert property (p_kern) else $error("user store outside kernel");
	property p_umap; s_swu ##0 xlate_rsp_in.seg_mode == SEG_MAPPED_USER_KERNEL_MODE |-> xlate_req_out.user_map;
	endproperty
	a_umap: assert property (p_umap) else $error("user mapping not used");
	property p_addr; issue_valid_in && major == OP_STORE_WORD |-> xlate_req_out.vaddr
		== issue_in.gpr_b + {{48{issue_in.word[15]}}, issue_in.word[15:0]}; endproperty
	a_addr: assert property (p_addr) else $error("address sum wrong");
endmodule
bind ssw_exec ssw_checker ssw_checker_i (.*);
`default_nettype wire

// ---- verif/subtract_store_word_exec_bench.sv ----
// Self-checking bench for the subtract and word-store block
`timescale 1ns/1ps
`default_nettype none
module subtract_store_word_exec_bench;
	import ssw_pkg::*;
	typedef struct {logic [31:0] w; logic [63:0] a, b; ssw_op_t op; ssw_exc_t exc; logic [63:0] v;} ssw_row_t;
	localparam logic [63:0] D = 64'h12345678;
	localparam logic [63:0] DH = 64'h1234567800000000;
	localparam logic [63:0] NEG = 64'hFFFFFFFF80000000;
	localparam logic [31:0] W_WSUB = {OP_MAJOR_A, 15'h0443, 1'h0, FN_WRAP_SUB};
	localparam logic [31:0] W_TSUB = {OP_MAJOR_A, 15'h0443, 1'h0, FN_TRAP_SUB};
	localparam logic [31:0] W_SW = {OP_STORE_WORD, 10'h022, 16'hFFFC};
	localparam logic [31:0] W_SWF = {OP_FP_STORE, 10'h022, 16'h0000};
	localparam logic [31:0] W_COP2_STORE_WORD = {OP_MAJOR_B, 10'h022, SUB_COP2_STORE, 1'h0, 11'h7FC};
	localparam logic [31:0] W_SWU = {OP_MAJOR_C, 10'h022, SUB_ENH_STORE, SUB_USER_STORE, 9'h1F8};
	localparam logic [31:0] W_FSUB = {OP_MAJOR_FP, 15'h0443, 1'h0, FMT_DOUBLE, FN_FP_SUB};
	localparam logic [31:0] W_FPS = {OP_MAJOR_FP, 15'h0443, 1'h0, FMT_PAIRED, FN_FP_SUB};
	logic ref_clk_in = 0, arst_n_in = 0, issue_valid_in = 0, kernel_mode_in = 1, fpu_usable_in = 1;
	logic cop2_usable_in = 1, enhanced_vaddr_present_in = 1, big_endian_flag_in = 0;
	logic reversed_endian_flag_in = 0, fp_bad = 0, store_valid_out, exc_valid_out;
	logic [1:0] fp_control_status_rm_in = 2'h2, seg = SEG_MAPPED_USER_KERNEL_MODE;
	logic [4:0] fault = 5'h00;
	logic [63:0] fp_result_in;
	ssw_issue_t issue_in = '0;
	ssw_xlate_req_t xlate_req_out;
	ssw_xlate_rsp_t xlate_rsp_in;
	ssw_fp_req_t fp_req_out;
	ssw_fp_flags_t fp_flags_in, exc_fp_flags_out;
	ssw_store_t store_out;
	ssw_wb_t wb_out;
	ssw_exc_t exc_code_out;
	ssw_op_t op_out;
	int fails = 0, total_checks = 0;
	ssw_exc_t fc [5] = '{SSW_EXC_TLB_REFILL, SSW_EXC_TLB_INVALID, SSW_EXC_TLB_MODIFIED,
		SSW_EXC_BUS_ERR, SSW_EXC_WATCH};
	// Word operands stay sign-extended
	ssw_row_t rows [10] = '{'{W_WSUB, 64'h1, 64'h0, SSW_OP_WSUB, SSW_EXC_NONE, '1},
		'{W_WSUB, 64'h1, NEG, SSW_OP_WSUB, SSW_EXC_NONE, 64'h7FFFFFFF},
		'{W_TSUB, 64'h1, NEG, SSW_OP_TSUB, SSW_EXC_OVERFLOW, 64'h0},
		'{W_TSUB, 64'h3, 64'h5, SSW_OP_TSUB, SSW_EXC_NONE, 64'h2},
		'{W_SW, D, 64'h100, SSW_OP_SW, SSW_EXC_NONE, DH},
		'{W_SWF, D, 64'h8, SSW_OP_SWF, SSW_EXC_NONE, D},
		'{W_COP2_STORE_WORD, D, 64'h10, SSW_OP_COP2_STORE_WORD, SSW_EXC_NONE, DH},
		'{W_SWU, D, 64'h20, SSW_OP_SWU, SSW_EXC_NONE, D},
		'{W_FSUB, 64'h4, 64'h9, SSW_OP_FSUB, SSW_EXC_NONE, 64'h5},
		'{32'hFFFFFFFF, 64'h0, 64'h0, SSW_OP_NONE, SSW_EXC_NONE, 64'h0}};
	ssw_exec ssw_exec_i (.*);
	ssw_far_model ssw_far_model_i (.req_in(xlate_req_out), .fp_req_in(fp_req_out), .seg_in(seg),
		.fault_in(fault), .fp_bad_in(fp_bad), .rsp_out(xlate_rsp_in), .fp_res_out(fp_result_in),
		.fp_flags_out(fp_flags_in));
	always #2.5 ref_clk_in = ~ref_clk_in;
	task automatic chk(input logic [63:0] s, e);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic issue(input logic [31:0] w, input logic [63:0] a, b);
		@(posedge ref_clk_in);
		issue_valid_in <= 1'h1;
		issue_in <= {w, a, b, a, a};
		@(posedge ref_clk_in);
		issue_valid_in <= 1'h0;
		#1;
	endtask
	task automatic report_and_stop();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		fails++;
		report_and_stop();
	end
	initial begin
		repeat (10) @(posedge ref_clk_in);
		arst_n_in <= 1'h1;
		@(posedge ref_clk_in);
		#1;
		chk(op_out, SSW_OP_NONE);
		chk({store_valid_out, exc_valid_out}, 0);
		for (int i = 0; i < 10; i++) begin
			issue(rows[i].w, rows[i].a, rows[i].b);
			chk(op_out, rows[i].op);
			chk(exc_code_out, rows[i].exc);
			chk(store_valid_out, rows[i].op >= SSW_OP_SW
				&& rows[i].exc == SSW_EXC_NONE);
			if (rows[i].op >= SSW_OP_SW) begin
				chk(store_out.data, rows[i].v);
			end else if (rows[i].op != SSW_OP_NONE && rows[i].exc == SSW_EXC_NONE) begin
				chk(wb_out.value, rows[i].v);
			end else begin
				chk(wb_out.gpr_we, 0);
			end
		end
		for (int k = 0; k < 5; k++) begin
			fault <= 5'h10 >> k;
			issue(k == 3 ? W_SWU : W_SW, D, 64'h100);
			chk(exc_code_out, fc[k]);
			chk(store_valid_out, 0);
		end
		fault <= 5'h00;
		for (int k = 0; k < 4; k++) begin
			seg <= 2'(k);
			issue(W_SWU, D, 64'h20);
			chk(store_valid_out, k != 0);
		end
		kernel_mode_in <= 1'h0;
		issue(W_SWU, D, 64'h20);
		chk(exc_code_out, SSW_EXC_ADDR_ERR);
		kernel_mode_in <= 1'h1;
		enhanced_vaddr_present_in <= 1'h0;
		issue(W_SWU, D, 64'h20);
		chk(exc_code_out, SSW_EXC_RESERVED);
		enhanced_vaddr_present_in <= 1'h1;
		fp_bad <= 1'h1;
		issue(W_FSUB, 64'h4, 64'h9);
		chk({exc_code_out, exc_fp_flags_out, wb_out.fpr_we}, {SSW_EXC_FPU, 5'h10, 1'h0});
		fp_bad <= 1'h0;
		fpu_usable_in <= 1'h0;
		issue(W_FSUB, 64'h4, 64'h9);
		chk(exc_code_out, SSW_EXC_COP_UNUSABLE);
		fpu_usable_in <= 1'h1;
		issue(W_FPS, 64'h4, 64'h9);
		chk(wb_out.fpr_we, 0);
		chk({wb_out.dest, wb_out.fmt}, {5'h03, FMT_PAIRED});
		big_endian_flag_in <= 1'h1;
		issue(W_SW, D, 64'h100);
		chk({store_out.data, store_out.byte_en}, {D, 8'h0F});
		chk(store_out.vaddr, 64'hFC);
		chk(store_out.cca, 3'h3);
		reversed_endian_flag_in <= 1'h1;
		issue(W_SW, D, 64'h100);
		chk(store_out.paddr, 48'hF8);
		issue(W_SW, D, 64'h101);
		chk(exc_valid_out, 0);
		@(posedge ref_clk_in);
		issue_valid_in <= 1'h1;
		arst_n_in <= 1'h0;
		#1 chk(store_valid_out, 0);
		@(posedge ref_clk_in);
		arst_n_in <= 1'h1;
		@(posedge ref_clk_in);
		issue_valid_in <= 1'h0;
		#1 chk(store_valid_out, 1);
		report_and_stop();
	end
endmodule
`default_nettype wire
